// >>> pkg/sxle_consts.svh
`ifndef SXLE_CONSTS_SVH
`define SXLE_CONSTS_SVH

// register port geometry
`define SXLE_ADDR_W        12
`define SXLE_DATA_W        8
`define SXLE_LANES         8

// register offsets
`define SXLE_OFF_PD        12'h209
`define SXLE_OFF_EXTRA_A   12'h20a
`define SXLE_OFF_EXTRA_B   12'h20b
`define SXLE_OFF_CTRL      12'h220
`define SXLE_OFF_MODE      12'h221
`define SXLE_OFF_TEST      12'h222
`define SXLE_OFF_STATUS    12'h223
`define SXLE_OFF_SER_A     12'h224
`define SXLE_OFF_SER_B     12'h225

// reset values
`define SXLE_RST_PD        8'h00
`define SXLE_RST_EXTRA_A   8'h00
`define SXLE_RST_EXTRA_B   8'h00
`define SXLE_RST_MODE      8'h00
`define SXLE_RST_TEST      4'h0
`define SXLE_RST_EN        1'b0
`define SXLE_READ_IDLE     8'h00

// field positions
`define SXLE_SER_BIT       0
`define SXLE_EN_BIT        0
`define SXLE_PD_A_BIT      0
`define SXLE_PD_B_BIT      1
`define SXLE_TEST_W        4
`define SXLE_ST_ON_A       0
`define SXLE_ST_ON_B       1
`define SXLE_ST_SER_A      2
`define SXLE_ST_SER_B      3

`endif

// >>> pkg/sxle_pkg.sv
package sxle_pkg;

  typedef struct packed {
    logic [7:0] clk_en;
    logic [7:0] ser_clk;
  } sxle_lanes_t;

  typedef struct packed {
    logic [7:1] lane;
    logic       ser_en;
  } sxle_extra_t;

endpackage

// >>> core/sxle_lane_gate.sv
`timescale 1ns/100ps
`include "sxle_consts.svh"

module sxle_lane_gate (
  input  wire logic                   link_on,
  input  wire logic [7:0]             req_lanes,
  input  wire sxle_pkg::sxle_extra_t  extra,
  output sxle_pkg::sxle_lanes_t       lanes
);

  logic [7:0] active;
  logic [7:0] want_ser;
  logic       lower_ok;

  always_comb begin
    active      = 8'h00;
    want_ser    = 8'h00;
    lanes       = '0;
    lower_ok    = 1'b1;
    // base lane is never an extra lane
    active[0]   = link_on & req_lanes[0];
    want_ser[0] = active[0];
    for (int n = 1; n < `SXLE_LANES; n++) begin
      // powered-down link keeps every lane off
      active[n]   = link_on & (req_lanes[n] | extra.lane[n]);
      // extra lane gets only link-layer clock unless serializers enabled
      want_ser[n] = active[n] & (req_lanes[n] | extra.ser_en);
    end
    for (int n = 0; n < `SXLE_LANES; n++) begin
      // serializer clock chains through every lower lane
      lanes.ser_clk[n] = want_ser[n] & lower_ok;
      lower_ok         = lower_ok & active[n];
    end
    lanes.clk_en = active;
  end

endmodule

// >>> core/sxle_top.sv
// Overview of operation
// - Link A extra-lane bits 7..1 each turn on lane n even if the mode needs it not.
// - Link B extra-lane bits 7..1 each turn on lane n, exactly like link A.
// - With bit 0 clear, a lane-enable bit turns on only that lane's link-layer clock, not its serializer.
// - Bit 0 selects clocks only (0) or clocks plus powered serializers (1).
// - Extra lanes share the configured link mode and test pattern, no own rate.
// - Extra-lane bits never override channel power-down; a link must be on.
// - Serializer n is clocked only when every lower lane 0..n-1 is enabled.
// - The link B extra-lane register resets to 0x00.
// - Channel power-down also powers down that channel's serial lanes.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "sxle_consts.svh"

module sxle_top (
  input  wire logic                    SYS_CLK,
  input  wire logic                    SYS_RST,
  input  wire logic [`SXLE_ADDR_W-1:0] REG_ADDR,
  input  wire logic [`SXLE_DATA_W-1:0] REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output logic      [`SXLE_DATA_W-1:0] REG_RDATA,
  input  wire logic [7:0]              REQ_LANES_A,
  input  wire logic [7:0]              REQ_LANES_B,
  output logic      [7:0]              LANE_CLK_A,
  output logic      [7:0]              SER_CLK_A,
  output logic      [7:0]              LANE_CLK_B,
  output logic      [7:0]              SER_CLK_B,
  output logic      [7:0]              LANE_MODE,
  output logic      [`SXLE_TEST_W-1:0] LANE_TEST,
  output logic                         LINK_ACTIVE_A,
  output logic                         LINK_ACTIVE_B
);

  function automatic logic hit(
    input logic [`SXLE_ADDR_W-1:0] addr,
    input logic [`SXLE_ADDR_W-1:0] off
  );
    hit = (addr == off);
  endfunction

  logic [7:0]              extra_a_ff;
  logic [7:0]              extra_b_ff;
  logic [7:0]              pd_ff;
  logic                    en_ff;
  logic [7:0]              mode_ff;
  logic [`SXLE_TEST_W-1:0] test_ff;
  logic [7:0]              rdata_ff;
  logic [7:0]              nxt_rdata;
  logic                    link_on_a;
  logic                    link_on_b;
  sxle_pkg::sxle_extra_t   extra_a;
  sxle_pkg::sxle_extra_t   extra_b;
  sxle_pkg::sxle_lanes_t   gate_a;
  sxle_pkg::sxle_lanes_t   gate_b;
  sxle_pkg::sxle_lanes_t   lanes_a_ff;
  sxle_pkg::sxle_lanes_t   lanes_b_ff;
  logic [7:0]              mode_out_ff;
  logic [`SXLE_TEST_W-1:0] test_out_ff;
  logic                    on_a_ff;
  logic                    on_b_ff;

  // register writes
  // no write lock on the global enable: software keeps writes to quiet
  // times, and a change mid-frame only moves which lanes are gated
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      extra_a_ff <= `SXLE_RST_EXTRA_A;
    end else if (REG_WR && hit(REG_ADDR, `SXLE_OFF_EXTRA_A)) begin
      extra_a_ff <= REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      extra_b_ff <= `SXLE_RST_EXTRA_B;
    end else if (REG_WR && hit(REG_ADDR, `SXLE_OFF_EXTRA_B)) begin
      extra_b_ff <= REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pd_ff <= `SXLE_RST_PD;
    end else if (REG_WR && hit(REG_ADDR, `SXLE_OFF_PD)) begin
      pd_ff <= REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      en_ff <= `SXLE_RST_EN;
    end else if (REG_WR && hit(REG_ADDR, `SXLE_OFF_CTRL)) begin
      en_ff <= REG_WDATA[`SXLE_EN_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mode_ff <= `SXLE_RST_MODE;
    end else if (REG_WR && hit(REG_ADDR, `SXLE_OFF_MODE)) begin
      mode_ff <= REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      test_ff <= `SXLE_RST_TEST;
    end else if (REG_WR && hit(REG_ADDR, `SXLE_OFF_TEST)) begin
      test_ff <= REG_WDATA[`SXLE_TEST_W-1:0];
    end
  end

  // link state: power-down of a channel takes its lanes with it
  assign link_on_a = en_ff & ~pd_ff[`SXLE_PD_A_BIT];
  assign link_on_b = en_ff & ~pd_ff[`SXLE_PD_B_BIT];

  assign extra_a.lane   = extra_a_ff[7:1];
  assign extra_a.ser_en = extra_a_ff[`SXLE_SER_BIT];
  assign extra_b.lane   = extra_b_ff[7:1];
  assign extra_b.ser_en = extra_b_ff[`SXLE_SER_BIT];

  sxle_lane_gate u_gate_a (
    .link_on   (link_on_a),
    .req_lanes (REQ_LANES_A),
    .extra     (extra_a),
    .lanes     (gate_a)
  );

  sxle_lane_gate u_gate_b (
    .link_on   (link_on_b),
    .req_lanes (REQ_LANES_B),
    .extra     (extra_b),
    .lanes     (gate_b)
  );

  // registered gate outputs keep glitches off the clock-gate enables
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      lanes_a_ff <= '0;
      lanes_b_ff <= '0;
    end else begin
      lanes_a_ff <= gate_a;
      lanes_b_ff <= gate_b;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      on_a_ff <= 1'b0;
      on_b_ff <= 1'b0;
    end else begin
      on_a_ff <= link_on_a;
      on_b_ff <= link_on_b;
    end
  end

  // one mode and pattern for all lanes, extra ones included
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mode_out_ff <= `SXLE_RST_MODE;
      test_out_ff <= `SXLE_RST_TEST;
    end else begin
      mode_out_ff <= mode_ff;
      test_out_ff <= test_ff;
    end
  end

  // read mux
  always_comb begin
    nxt_rdata = `SXLE_READ_IDLE;
    if (REG_RD) begin
      case (1'b1)
        hit(REG_ADDR, `SXLE_OFF_PD):      nxt_rdata = pd_ff;
        hit(REG_ADDR, `SXLE_OFF_EXTRA_A): nxt_rdata = extra_a_ff;
        hit(REG_ADDR, `SXLE_OFF_EXTRA_B): nxt_rdata = extra_b_ff;
        hit(REG_ADDR, `SXLE_OFF_CTRL):    nxt_rdata = {7'h00, en_ff};
        hit(REG_ADDR, `SXLE_OFF_MODE):    nxt_rdata = mode_ff;
        hit(REG_ADDR, `SXLE_OFF_TEST):    nxt_rdata = {4'h0, test_ff};
        hit(REG_ADDR, `SXLE_OFF_STATUS): begin
          nxt_rdata[`SXLE_ST_ON_A]  = on_a_ff;
          nxt_rdata[`SXLE_ST_ON_B]  = on_b_ff;
          nxt_rdata[`SXLE_ST_SER_A] = |lanes_a_ff.ser_clk;
          nxt_rdata[`SXLE_ST_SER_B] = |lanes_b_ff.ser_clk;
        end
        hit(REG_ADDR, `SXLE_OFF_SER_A):   nxt_rdata = lanes_a_ff.ser_clk;
        hit(REG_ADDR, `SXLE_OFF_SER_B):   nxt_rdata = lanes_b_ff.ser_clk;
        default:                          nxt_rdata = `SXLE_READ_IDLE;
      endcase
    end
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rdata_ff <= `SXLE_READ_IDLE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA     = rdata_ff;
  assign LANE_CLK_A    = lanes_a_ff.clk_en;
  assign SER_CLK_A     = lanes_a_ff.ser_clk;
  assign LANE_CLK_B    = lanes_b_ff.clk_en;
  assign SER_CLK_B     = lanes_b_ff.ser_clk;
  assign LANE_MODE     = mode_out_ff;
  assign LANE_TEST     = test_out_ff;
  assign LINK_ACTIVE_A = on_a_ff;
  assign LINK_ACTIVE_B = on_b_ff;

  default clocking cb @(posedge SYS_CLK);
  endclocking

  default disable iff (SYS_RST);

  a_reset_a_zero: assert property (
    $fell(SYS_RST) |-> extra_a_ff == 8'h00 && SER_CLK_A == 8'h00
  ) else $error("link a extra lanes not clear after reset");

  a_reset_b_zero: assert property (
    $fell(SYS_RST) |-> extra_b_ff == 8'h00 && SER_CLK_B == 8'h00
  ) else $error("link b extra lanes not clear after reset");

  a_write_a_lands: assert property (
    REG_WR && REG_ADDR == `SXLE_OFF_EXTRA_A
      |=> extra_a_ff == $past(REG_WDATA)
  ) else $error("link a extra write lost");

  a_write_b_lands: assert property (
    REG_WR && REG_ADDR == `SXLE_OFF_EXTRA_B
      |=> extra_b_ff == $past(REG_WDATA)
  ) else $error("link b extra write lost");

  a_extra_lane_a: assert property (
    (link_on_a && extra_a_ff[5])
      |=> LANE_CLK_A[5]
  ) else $error("link a extra lane clock missing");

  a_extra_lane_b: assert property (
    (link_on_b && extra_b_ff[3])
      |=> LANE_CLK_B[3]
  ) else $error("link b extra lane clock missing");

  a_extra_clk_only: assert property (
    (link_on_a && extra_a_ff[1] && !extra_a_ff[0] && !REQ_LANES_A[1])
      |=> LANE_CLK_A[1] && !SER_CLK_A[1]
  ) else $error("extra lane serializer on without enable");

  a_clk_only_b: assert property (
    (link_on_b && extra_b_ff[2] && !extra_b_ff[0] && !REQ_LANES_B[2])
      |=> LANE_CLK_B[2] && !SER_CLK_B[2]
  ) else $error("link b extra serializer on without enable");

  a_ser_select: assert property (
    (link_on_a && REQ_LANES_A[0] && extra_a_ff[1] && extra_a_ff[0])
      |=> SER_CLK_A[1]
  ) else $error("serializer enable ignored");

  a_ser_select_b: assert property (
    (link_on_b && REQ_LANES_B[0] && extra_b_ff[1] && extra_b_ff[0])
      |=> SER_CLK_B[1]
  ) else $error("link b serializer enable ignored");

  a_mode_shared: assert property (
    ##1 LANE_MODE == $past(mode_ff) && LANE_TEST == $past(test_ff)
  ) else $error("lane mode differs from link mode");

  a_pd_forces_off: assert property (
    (pd_ff[`SXLE_PD_A_BIT] || !en_ff)
      |=> LANE_CLK_A == 8'h00 && SER_CLK_A == 8'h00
  ) else $error("powered-down link a has live lanes");

  a_pd_lanes_b: assert property (
    pd_ff[`SXLE_PD_B_BIT] [*2] |-> LANE_CLK_B == 8'h00 && !LINK_ACTIVE_B
  ) else $error("powered-down link b has live lanes");

  a_pd_lanes_a: assert property (
    pd_ff[`SXLE_PD_A_BIT] [*2] |-> SER_CLK_A == 8'h00 && !LINK_ACTIVE_A
  ) else $error("powered-down link a has live serializers");

  a_chain_gate: assert property (
    SER_CLK_A[3] |-> &LANE_CLK_A[2:0]
  ) else $error("serializer clocked with a lower lane off");

  a_chain_gate_b: assert property (
    SER_CLK_B[7] |-> &LANE_CLK_B[6:0]
  ) else $error("link b serializer clocked with a lower lane off");

  a_read_latency: assert property (
    REG_RD && REG_ADDR == `SXLE_OFF_EXTRA_B
      |=> REG_RDATA == $past(extra_b_ff)
          ##1 ($past(REG_RD) || REG_RDATA == 8'h00)
  ) else $error("read data timing wrong");

  // read data must drop back to idle outside the answer cycle
  a_read_idle: assert property (
    !REG_RD |=> REG_RDATA == `SXLE_READ_IDLE
  ) else $error("read data outside read cycle");

  c_link_a_serializer_enable: cover property (SER_CLK_A[7]);
  c_extra_clk_b: cover property (LANE_CLK_B[7] && !SER_CLK_B[7]);
  c_chain_break: cover property (LANE_CLK_A[5] && !LANE_CLK_A[2]);
  c_pd_with_extra: cover property (pd_ff[0] && extra_a_ff != 8'h00);

endmodule

// >>> bench/sxle_req_src.sv
`timescale 1ns/100ps

module sxle_req_src (
  input  wire logic [7:0] mode,
  output logic      [7:0] req_a,
  output logic      [7:0] req_b
);
  // stands in for the mode-to-lane map: bit 3/7 off means no lanes at all
  assign req_a = mode[3] ? (8'h02 << mode[2:0]) - 8'h01 : 8'h00;
  assign req_b = mode[7] ? (8'h02 << mode[6:4]) - 8'h01 : 8'h00;
endmodule

// >>> bench/tb.sv
`timescale 1ns/100ps
`include "sxle_consts.svh"
`define CHK(nm, e, s) \
  comparisons++; \
  if ((s) !== (e)) begin \
    err_total++; \
    $display("Error %s exp %h got %h", nm, e, s); \
  end

module tb;
  logic        clk, rst, wr, rd, aa, ab;
  logic [11:0] addr;
  logic [7:0]  wd, rdata, rqa, rqb, lca, sca, lcb, scb, mode, d;
  logic [7:0]  pd, ea, eb, md;
  logic [3:0]  test, ts;
  logic [31:0] r;
  logic [15:0] xa, xb;
  int          err_total, comparisons, cyc, seed, i;

  sxle_top sxle_top_i (
    .SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REQ_LANES_A(rqa), .REQ_LANES_B(rqb),
    .LANE_CLK_A(lca), .SER_CLK_A(sca), .LANE_CLK_B(lcb), .SER_CLK_B(scb),
    .LANE_MODE(mode), .LANE_TEST(test),
    .LINK_ACTIVE_A(aa), .LINK_ACTIVE_B(ab)
  );

  sxle_req_src sxle_req_src_i (.mode(mode), .req_a(rqa), .req_b(rqb));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // lane 0 is never extra; serializers chain on all lower lanes
  function automatic logic [15:0] lanes(input logic on,
                                        input logic [7:0] rq,
                                        input logic [7:0] ex);
    logic [7:0] act;
    logic [7:0] ser;
    logic       low;
    low = 1'b1;
    for (int n = 0; n < 8; n++) begin
      act[n] = on & (rq[n] | (n != 0 && ex[n]));
      ser[n] = act[n] & low & (n == 0 || rq[n] || ex[0]);
      low = low & act[n];
    end
    return {act, ser};
  endfunction

  task automatic chk_rst();
    rd_reg(`SXLE_OFF_EXTRA_A, d);
    `CHK("rst_a", 8'h00, d)
    rd_reg(`SXLE_OFF_EXTRA_B, d);
    `CHK("rst_b", 8'h00, d)
    `CHK("rst_out", 32'h0000_0000, {lca, sca, lcb, scb})
  endtask

  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    seed = 85812;
    {rst, wr, rd} = 3'b100;
    addr = '0;
    wd = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk_rst();
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      {md, eb, ea, pd} = r;
      r = $random(seed);
      ts = r[3:0];
      // extra-lane settings only move while the link is off
      wr_reg(`SXLE_OFF_CTRL, 8'h00);
      @(posedge clk);
      #1;
      `CHK("off", 16'h0000, {lca, lcb})
      wr_reg(`SXLE_OFF_PD, pd);
      wr_reg(`SXLE_OFF_EXTRA_A, ea);
      wr_reg(`SXLE_OFF_EXTRA_B, eb);
      wr_reg(`SXLE_OFF_MODE, md);
      wr_reg(`SXLE_OFF_TEST, {4'h0, ts});
      wr_reg(`SXLE_OFF_CTRL, 8'h01);
      @(posedge clk);
      #1;
      xa = lanes(~pd[0], md[3] ? (8'h02 << md[2:0]) - 8'h01 : 8'h00, ea);
      xb = lanes(~pd[1], md[7] ? (8'h02 << md[6:4]) - 8'h01 : 8'h00, eb);
      `CHK("lane_a", xa[15:8], lca)
      `CHK("ser_a", xa[7:0], sca)
      `CHK("lane_b", xb[15:8], lcb)
      `CHK("ser_b", xb[7:0], scb)
      `CHK("active", {~pd[1], ~pd[0]}, {ab, aa})
      `CHK("mode", {md, ts}, {mode, test})
      rd_reg(`SXLE_OFF_EXTRA_A, d);
      `CHK("extra_a", ea, d)
      rd_reg(`SXLE_OFF_EXTRA_B, d);
      `CHK("extra_b", eb, d)
      rd_reg(`SXLE_OFF_PD, d);
      `CHK("pd", pd, d)
      rd_reg(`SXLE_OFF_STATUS, d);
      `CHK("status", {4'h0, |xb[7:0], |xa[7:0], ~pd[1], ~pd[0]}, d)
      // read-only and unmapped places must ignore writes
      wr_reg(`SXLE_OFF_SER_A, r[11:4]);
      rd_reg(`SXLE_OFF_SER_A, d);
      `CHK("ser_ro", xa[7:0], d)
      wr_reg(12'h210, r[19:12]);
      rd_reg(12'h210, d);
      `CHK("unmapped", 8'h00, d)
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_rst();
    close_out();
  end
endmodule
